// ==== common/biu_map.svh ====
/*
 * Constants for the bus interface unit: transfer codes, sizes, depths, vectors.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef BIU_MAP_SVH
`define BIU_MAP_SVH
`define BIU_TRANS_IDLE 2'h0
`define BIU_TRANS_NONSEQ 2'h2
`define BIU_TRANS_SEQ 2'h3
`define BIU_BURST_SINGLE 3'h0
`define BIU_BURST_INCR 3'h1
`define BIU_SIZE_WORD 3'h2
`define BIU_WB_DEPTH 5
`define BIU_HIGH_VECTOR_BASE 32'hffff0000
`define BIU_LOW_VECTOR_BASE 32'h00000000
`define BIU_KB_BOUNDARY_BIT 10
`define BIU_WORD_STEP 32'h00000004
`define BIU_TCM_VECTOR_CYCLES 2'h3
`define BIU_PROT_OPCODE 4'h0
`define BIU_PROT_DATA 4'h1
`define BIU_PROT_BUFFERABLE 4'h5
`endif

// ==== common/biu_pkg.sv ====
/*
 * Types shared by the bus interface unit and its helpers.
 * Assumes the constants header sits in the include path.
 */
`include "biu_map.svh"
package biu_pkg;
    // Kind of a core request
    typedef enum logic [1:0] {
        BIU_REQ_FETCH,
        BIU_REQ_LOAD,
        BIU_REQ_STORE
    } biu_req_kind_t;
    // Bus sequencer states
    typedef enum logic [2:0] {
        BIU_ST_IDLE,
        BIU_ST_ADDR,
        BIU_ST_DATA,
        BIU_ST_TAIL
    } biu_state_t;
endpackage : biu_pkg

// ==== verilog/biu_sync_tracker.sv ====
/*
 * Tracks whether the sequencer is still locked to the bus edge pattern.
 * Assumes bus_edge_enable is already synchronous to sys_clk.
 */
`timescale 1ns/1ps
module biu_sync_tracker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bus_edge_enable,
    input wire logic bus_active,
    input wire logic core_internal,
    output logic in_sync
);
    import biu_pkg::*;
    logic in_sync_r;
    // Lock held while the bus stays busy; lost on an idle core cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_sync_r <= 1'b0;
        end else if (core_internal) begin
            in_sync_r <= 1'b0;
        end else if (bus_edge_enable && bus_active) begin
            in_sync_r <= 1'b1;
        end else if (!bus_active) begin
            in_sync_r <= 1'b0;
        end
    end
    assign in_sync = in_sync_r;
endmodule : biu_sync_tracker

// ==== verilog/biu_write_buffer.sv ====
/*
 * Write buffer: in-order store queue of flip-flops, valid and ready on both sides.
 * Assumes the drain side holds ready low until the bus takes the word.
 */
`timescale 1ns/1ps
`include "biu_map.svh"
module biu_write_buffer #(
    parameter int DEPTH = `BIU_WB_DEPTH,
    parameter int WIDTH = 64
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    import biu_pkg::*;
    localparam int AW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] rd_r;
    logic [AW-1:0] wr_r;
    logic [AW-1:0] count_r;
    logic push;
    logic pop;
    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : wrap_inc
    assign in_ready = (count_r != AW'(DEPTH));
    assign out_valid = (count_r != '0);
    assign empty = (count_r == '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_r];
    // Storage written only at the tail, so order of acceptance is kept
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data; // R18
        end
    end
    // Pointers and fill level
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_r <= '0;
            wr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wrap_inc(wr_r);
            end
            if (pop) begin
                rd_r <= wrap_inc(rd_r); // R18
            end
            if (push && !pop) begin
                count_r <= count_r + AW'(1);
            end else if (pop && !push) begin
                count_r <= count_r - AW'(1);
            end
        end
    end
endmodule : biu_write_buffer

// ==== verilog/biu_master.sv ====
/*
 * Bus interface unit: turns core fetches, loads and stores into bus master
 * transfers, buffering stores and stalling the core while it waits.
 * Assumes every input is synchronous to sys_clk and the unit is default master.
 */

// What this block does
// R01: Buffered stores cost sync, NONSEQ, SEQs and one IDLE, core runs on.
// R02: Unbuffered access after drain stalls core until buffer empty and access done.
// R03: Fetch after last drained store replaces the IDLE with NONSEQ.
// R04: Buffer holds up to five words; fast interrupt stalls while they drain.
// R05: Load multiple breaks burst at 1KB; no fetch merged at its end.
// R06: Fetch after core internal cycle pays sync; next sequential fetch does not.
// R07: Outstanding load multiple finishes before vector fetch begins.
// R08: Vectors in local RAM are served locally, execute three cycles later.
// R09: High vector base at 0xffff0000 fetched over the system bus.
// R10: Each IDLE slot lasts one bus cycle, R core cycles.
// R11: All activity on rising sys_clk; outputs change only after an edge.
// R12: Every port is input or output; nothing bidirectional.
// R13: Surroundings present all inputs synchronous, interrupts included.
// R14: Transfer type IDLE 00, NONSEQ 10, SEQ 11; BUSY never issued.
// R15: Surroundings raise bus edge enable before a shared edge, tie high at 1:1.
// R16: New access waits for next bus edge enable, 0 to R-1 cycles.
// R17: Bursts, sequential fetches and paired requests pay sync once.
// R18: Stores drain in order; loads and fetches wait for empty buffer.
// R19: Core enable low while a read or unbuffered write waits; released at done.

`timescale 1ns/1ps
`include "biu_map.svh"

module biu_master #(
    parameter int DEPTH = `BIU_WB_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bus_edge_enable,
    input wire logic req_valid,
    input wire biu_pkg::biu_req_kind_t req_kind,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic req_bufferable,
    input wire logic req_seq,
    input wire logic req_last,
    input wire logic core_internal,
    input wire logic fast_interrupt_request,
    input wire logic high_vector_select,
    input wire logic vector_fetch,
    output logic core_clock_enable,
    output logic [31:0] core_rdata,
    output logic rdata_valid,
    output logic vector_from_tcm,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [2:0] hburst,
    output logic [3:0] hprot,
    output logic [31:0] hwdata,
    output logic hbusreq,
    input wire logic [31:0] hrdata,
    input wire logic hready,
    input wire logic [1:0] hresp
);
    import biu_pkg::*;

    // Sequencer state and bus-side registers, one per output except the constant hsize
    biu_state_t state_r;
    logic [31:0] haddr_r;
    logic [1:0] htrans_r;
    logic hwrite_r;
    logic [2:0] hburst_r;
    logic [3:0] hprot_r;
    logic [31:0] hwdata_r;
    logic [31:0] pend_wdata_r;
    logic hbusreq_r;
    logic cce_r;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic vtcm_r;

    // Context of the transfer under way
    logic [31:0] last_addr_r;
    logic cur_write_r;
    logic cur_buffered_r;

    // Queue, lock and request decode
    logic wb_in_ready;
    logic wb_out_valid;
    logic wb_pop;
    logic [63:0] wb_out_data;
    logic wb_empty;
    logic in_sync;
    logic bus_active;
    logic store_push;
    logic direct_req;
    logic stall_req;
    logic bus_step;

    // True when two addresses lie in different 1KB regions
    function automatic logic crosses_kb(input logic [31:0] prev, input logic [31:0] nxt);
        crosses_kb = (prev[31:`BIU_KB_BOUNDARY_BIT] != nxt[31:`BIU_KB_BOUNDARY_BIT]);
    endfunction : crosses_kb

    // Buffered stores enter the queue; unbuffered accesses go straight to the bus
    assign store_push = req_valid && (req_kind == BIU_REQ_STORE) && req_bufferable;
    assign direct_req = req_valid && !store_push && !vector_local();
    assign bus_step = bus_edge_enable && hready; // R10 R16
    assign bus_active = (state_r != BIU_ST_IDLE) || wb_out_valid;

    // A direct request stalls the core; it also waits behind buffered words
    assign stall_req = direct_req || (store_push && !wb_in_ready) // R02 R04
        || (fast_interrupt_request && !wb_empty); // R04

    // Vector fetches stay local unless the high base is chosen;
    // the high base lies outside local RAM, so it goes over the bus
    function automatic logic vector_local();
        vector_local = vector_fetch && !high_vector_select; // R08 R09
    endfunction : vector_local

    // Store queue; a full queue holds the core, and its depth
    // bounds the drain ahead of a fast interrupt
    biu_write_buffer #(
        .DEPTH(DEPTH),
        .WIDTH(64)
    ) u_wb (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(store_push),
        .in_ready(wb_in_ready),
        .in_data({req_addr, req_wdata}),
        .out_valid(wb_out_valid),
        .out_ready(wb_pop),
        .out_data(wb_out_data),
        .empty(wb_empty)
    );

    // Lock to the bus edge pattern, dropped by a core internal cycle
    biu_sync_tracker u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .bus_edge_enable(bus_edge_enable),
        .bus_active(bus_active || direct_req),
        .core_internal(core_internal),
        .in_sync(in_sync)
    );

    // The queue head leaves only when its address phase is taken on a bus edge
    assign wb_pop = bus_step && wb_out_valid && (state_r == BIU_ST_IDLE || state_r == BIU_ST_DATA)
        && !(state_r == BIU_ST_DATA && !cur_write_r); // R18

    // Bus sequencer: address phase, data phase, trailing IDLE slot
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= BIU_ST_IDLE;
            haddr_r <= '0;
            htrans_r <= `BIU_TRANS_IDLE;
            hwrite_r <= 1'b0;
            hburst_r <= `BIU_BURST_SINGLE;
            hprot_r <= `BIU_PROT_OPCODE;
            hwdata_r <= '0;
            pend_wdata_r <= '0;
            last_addr_r <= '0;
            cur_write_r <= 1'b0;
            cur_buffered_r <= 1'b0;
        end else if (bus_step) begin // R11 R16
            if (wb_pop) begin
                // Drain head of buffer first; SEQ if it continues a store burst
                haddr_r <= wb_out_data[63:32];
                htrans_r <= (state_r == BIU_ST_DATA && cur_buffered_r && in_sync
                    && wb_out_data[63:32] == last_addr_r + `BIU_WORD_STEP
                    && !crosses_kb(last_addr_r, wb_out_data[63:32]))
                    ? `BIU_TRANS_SEQ : `BIU_TRANS_NONSEQ; // R01 R14 R17
                hburst_r <= `BIU_BURST_INCR;
                hwrite_r <= 1'b1;
                hprot_r <= `BIU_PROT_BUFFERABLE;
                pend_wdata_r <= wb_out_data[31:0];
                last_addr_r <= wb_out_data[63:32];
                cur_write_r <= 1'b1;
                cur_buffered_r <= 1'b1;
                if (state_r == BIU_ST_DATA) begin
                    hwdata_r <= pend_wdata_r;
                end
                state_r <= BIU_ST_DATA;
            end else if (direct_req && wb_empty && state_r != BIU_ST_ADDR // R07 R18
                && !(state_r == BIU_ST_TAIL && !cur_buffered_r) // R19
                && (state_r != BIU_ST_DATA || req_kind == BIU_REQ_FETCH)) begin // R02 R03
                // Only a fetch takes the IDLE slot after the last store; a finished
                // direct request still stands in its tail cycle and is not taken twice
                haddr_r <= req_addr;
                // One direct transfer per stall, so each one opens with NONSEQ
                htrans_r <= `BIU_TRANS_NONSEQ; // R05 R06 R14
                hburst_r <= req_seq ? `BIU_BURST_INCR : `BIU_BURST_SINGLE;
                hwrite_r <= (req_kind == BIU_REQ_STORE);
                hprot_r <= (req_kind == BIU_REQ_FETCH) ? `BIU_PROT_OPCODE : `BIU_PROT_DATA;
                pend_wdata_r <= req_wdata;
                last_addr_r <= req_addr;
                cur_write_r <= (req_kind == BIU_REQ_STORE);
                cur_buffered_r <= 1'b0;
                if (state_r == BIU_ST_DATA) begin
                    hwdata_r <= pend_wdata_r;
                end
                state_r <= BIU_ST_ADDR;
            end else begin
                unique case (state_r)
                    BIU_ST_IDLE: begin
                        htrans_r <= `BIU_TRANS_IDLE;
                    end
                    BIU_ST_ADDR: begin
                        // Direct access data phase; one request per stall
                        htrans_r <= `BIU_TRANS_IDLE;
                        hwdata_r <= pend_wdata_r;
                        state_r <= BIU_ST_TAIL;
                    end
                    BIU_ST_DATA: begin
                        // Last store data phase followed by a single IDLE slot
                        htrans_r <= `BIU_TRANS_IDLE; // R01 R10
                        hwdata_r <= pend_wdata_r;
                        state_r <= BIU_ST_TAIL;
                    end
                    BIU_ST_TAIL: begin
                        // Bus back at rest; a later access waits for its own bus edge
                        htrans_r <= `BIU_TRANS_IDLE; // R14
                        cur_buffered_r <= 1'b0;
                        state_r <= BIU_ST_IDLE;
                    end
                    default: begin
                        state_r <= BIU_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Bus request held while anything is queued or under way
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hbusreq_r <= 1'b0;
        end else begin
            hbusreq_r <= bus_active || direct_req;
        end
    end

    // Core stall: low while a read or unbuffered write waits on the bus
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cce_r <= 1'b1;
        end else if (state_r == BIU_ST_TAIL && !cur_buffered_r && bus_step) begin
            cce_r <= 1'b1; // R19
        end else if (stall_req) begin
            cce_r <= 1'b0; // R02 R04 R19
        end else if (state_r == BIU_ST_IDLE) begin
            cce_r <= 1'b1; // R01
        end
    end

    // Read data captured on completion of the data phase
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= 1'b0;
            if (state_r == BIU_ST_TAIL && !cur_write_r && !cur_buffered_r && bus_step) begin
                rdata_r <= hrdata; // R11
                rvalid_r <= 1'b1;
            end
        end
    end

    // Local vector fetch: answer marked after the fixed local latency
    logic [1:0] vcnt_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vcnt_r <= '0;
            vtcm_r <= 1'b0;
        end else begin
            vtcm_r <= 1'b0;
            if (req_valid && vector_local() && vcnt_r == '0) begin
                vcnt_r <= `BIU_TCM_VECTOR_CYCLES - 2'h1; // R08
            end else if (vcnt_r != '0) begin
                vcnt_r <= vcnt_r - 2'h1;
                vtcm_r <= (vcnt_r == 2'h1);
            end
        end
    end

    // Ports driven straight from flip-flops, hsize from a constant; no bidirectional pins
    assign haddr = haddr_r; // R12
    assign htrans = htrans_r;
    assign hwrite = hwrite_r;
    // Transfers are always whole words
    assign hsize = `BIU_SIZE_WORD;
    assign hburst = hburst_r;
    assign hprot = hprot_r;
    assign hwdata = hwdata_r;
    assign hbusreq = hbusreq_r;
    assign core_clock_enable = cce_r;
    assign core_rdata = rdata_r;
    assign rdata_valid = rvalid_r;
    assign vector_from_tcm = vtcm_r;

endmodule : biu_master

// ==== verif/biu_master_monitor.sv ====
/* Port checks for the bus interface unit.
   Assumes a bind onto biu_master, one clock, reset low and asynchronous. */
`timescale 1ns/1ps
`include "biu_map.svh"
module biu_master_monitor (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bus_edge_enable,
    input wire logic hready,
    input wire logic req_valid,
    input wire biu_pkg::biu_req_kind_t req_kind,
    input wire logic vector_fetch,
    input wire logic high_vector_select,
    input wire logic core_clock_enable,
    input wire logic [31:0] core_rdata,
    input wire logic rdata_valid,
    input wire logic vector_from_tcm,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hrdata
);
    import biu_pkg::*;
    logic vec_local;
    // Local vector request as the core shows it
    assign vec_local = req_valid && vector_fetch && !high_vector_select;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // A fresh load while the core runs; back-to-back ones are not caught here
    sequence s_load_taken;
        req_valid && req_kind == BIU_REQ_LOAD && core_clock_enable && !rdata_valid
            && $past(core_clock_enable);
    endsequence
    sequence s_stall_start;
        $fell(core_clock_enable);
    endsequence
    a_trans_no_busy: assert property (htrans != 2'h1)
        else $error("busy transfer issued");
    a_size_word: assert property (hsize == `BIU_SIZE_WORD)
        else $error("size not word");
    a_bus_step_hold: assert property (!(bus_edge_enable && hready)
        |=> $stable(htrans) && $stable(haddr))
        else $error("bus changed off a bus step");
    a_seq_after_start: assert property (htrans == `BIU_TRANS_SEQ
        |-> $past(htrans) != `BIU_TRANS_IDLE)
        else $error("seq without a start");
    a_seq_in_kb: assert property (htrans == `BIU_TRANS_SEQ |-> haddr[9:0] != 10'h0)
        else $error("seq crossed 1KB");
    a_seq_addr_step: assert property ((htrans == `BIU_TRANS_SEQ && $changed(haddr))
        |-> haddr == $past(haddr) + 32'h4)
        else $error("seq address step");
    a_load_stalls: assert property (s_load_taken |=> !core_clock_enable)
        else $error("load did not stall");
    a_stall_bounded: assert property (s_stall_start |-> ##[1:600] core_clock_enable)
        else $error("stall never released");
    a_rdata_capture: assert property (rdata_valid
        |-> core_clock_enable && !$past(core_clock_enable) && core_rdata == $past(hrdata))
        else $error("read data capture");
    a_vector_local: assert property (vector_from_tcm |-> $past(vec_local, 3))
        else $error("local vector timing");
endmodule : biu_master_monitor

// ==== verif/biu_ahb_slave.sv ====
/* Bus slave and default arbiter stand-in, logs writes in arrival order.
   Assumes bus_edge_enable marks the sys_clk edges that are bus edges. */
`timescale 1ns/1ps
module biu_ahb_slave (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bus_edge_enable,
    input wire logic slow,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hready
);
    logic ph_v, ph_w;
    logic [31:0] ph_a;
    logic [31:0] log_a[$];
    logic [31:0] log_d[$];
    // Read data scrambles the address so the bench can predict it
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return a ^ 32'h3c5a96e1;
    endfunction : mem_word
    // Moves only on bus edges; idle read bus toggles so stale data never matches
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_v <= 1'b0;
            hready <= 1'b1;
            hrdata <= 32'h0;
        end else if (bus_edge_enable && hready) begin
            if (ph_v && ph_w) begin
                log_a.push_back(ph_a);
                log_d.push_back(hwdata);
            end
            ph_v <= htrans[1];
            ph_a <= haddr;
            ph_w <= hwrite;
            hready <= !(htrans[1] && slow);
            hrdata <= (htrans[1] && !hwrite && !slow) ? mem_word(haddr) : ~hrdata;
        end else if (bus_edge_enable) begin
            hready <= 1'b1;
            hrdata <= ph_w ? ~hrdata : mem_word(ph_a);
        end
    end
endmodule : biu_ahb_slave

// ==== verif/testbench.sv ====
/* Random and corner stimulus for the bus interface unit, checked against the slave log.
   Assumes the package, design, slave model and monitor are compiled before it. */
`timescale 1ns/1ps
module testbench;
    import biu_pkg::*;
    logic sys_clk, rst_b, bus_edge_enable, req_valid, req_bufferable, req_seq, req_last, slow;
    logic core_internal, fast_interrupt_request, high_vector_select, vector_fetch;
    logic core_clock_enable, rdata_valid, vector_from_tcm, hwrite, hbusreq, hready;
    biu_req_kind_t req_kind;
    logic [31:0] req_addr, req_wdata, core_rdata, haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, hburst;
    logic [3:0] hprot;
    int error_cnt, tests_run, cyc, ratio, ben_cnt, seed, waited, base_i;
    logic [31:0] exp_a[$];
    logic [31:0] exp_d[$];
    biu_master biu_master_i (.sys_clk(sys_clk), .rst_b(rst_b), .bus_edge_enable(bus_edge_enable),
        .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_bufferable(req_bufferable), .req_seq(req_seq), .req_last(req_last),
        .core_internal(core_internal), .fast_interrupt_request(fast_interrupt_request),
        .high_vector_select(high_vector_select), .vector_fetch(vector_fetch),
        .core_clock_enable(core_clock_enable), .core_rdata(core_rdata), .rdata_valid(rdata_valid),
        .vector_from_tcm(vector_from_tcm), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hburst(hburst), .hprot(hprot), .hwdata(hwdata), .hbusreq(hbusreq),
        .hrdata(hrdata), .hready(hready), .hresp(2'h0));
    biu_ahb_slave biu_ahb_slave_i (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
        .bus_edge_enable(bus_edge_enable), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hwdata(hwdata), .hrdata(hrdata), .hready(hready));
    always #20 sys_clk = ~sys_clk;
    // One bus edge every ratio core cycles, steady high at 1:1
    always @(negedge sys_clk) begin
        ben_cnt = (ben_cnt + 1) % ratio;
        bus_edge_enable <= (ben_cnt == 0);
    end
    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end
    function automatic logic [31:0] exp_rdata(input logic [31:0] a);
        return a ^ 32'h3c5a96e1;
    endfunction : exp_rdata
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Holds the request until the core enable is high after an edge
    task automatic core_req(input biu_req_kind_t k, input logic [31:0] a, input logic [31:0] d,
        input logic b, input logic s);
        waited = 0;
        req_valid = 1'b1;
        req_kind = k;
        req_addr = a;
        req_wdata = d;
        req_bufferable = b;
        req_seq = s;
        do begin
            @(posedge sys_clk);
            @(negedge sys_clk);
            waited = waited + 1;
        end while (core_clock_enable !== 1'b1 && waited < 700);
    endtask : core_req
    task automatic idle(input int n);
        req_valid = 1'b0;
        repeat (n) @(negedge sys_clk);
    endtask : idle
    // Stores, then a direct access that must wait for the whole drain
    task automatic batch(input int n, input logic [31:0] base, input logic sq);
        logic [31:0] a;
        logic [31:0] d;
        for (int i = 0; i < n; i++) begin
            a = sq ? base + 32'(4 * i) : ($random(seed) & 32'h0000fffc);
            d = $random(seed);
            exp_a.push_back(a);
            exp_d.push_back(d);
            core_req(BIU_REQ_STORE, a, d, 1'b1, sq && i > 0);
            chk("store cycles", 32'd1, 32'(waited));
        end
        fast_interrupt_request = (n == 5);
        a = $random(seed) & 32'h0000fffc;
        if (!sq) begin
            exp_a.push_back(a);
            exp_d.push_back(~a);
        end
        core_req(sq ? BIU_REQ_LOAD : BIU_REQ_STORE, a, ~a, 1'b0, 1'b0);
        if (sq) begin
            chk("load data", exp_rdata(a), core_rdata);
            chk("load valid", 32'd1, {31'h0, rdata_valid});
        end
        chk("write count", 32'(exp_a.size()),
            32'(biu_ahb_slave_i.log_a.size() - base_i));
        for (int i = 0; i < exp_a.size() && base_i + i < biu_ahb_slave_i.log_a.size(); i++) begin
            chk("write addr", exp_a[i], biu_ahb_slave_i.log_a[base_i + i]);
            chk("write data", exp_d[i], biu_ahb_slave_i.log_d[base_i + i]);
        end
        base_i = biu_ahb_slave_i.log_a.size();
        exp_a.delete();
        exp_d.delete();
        fast_interrupt_request = 1'b0;
        idle(2);
    endtask : batch
    task automatic fetches(input logic [31:0] a, input logic hv);
        int n;
        core_internal = 1'b1;
        idle(1);
        core_internal = 1'b0;
        core_req(BIU_REQ_FETCH, a, 32'h0, 1'b0, 1'b0);
        chk("fetch data", exp_rdata(a), core_rdata);
        core_req(BIU_REQ_FETCH, a + 32'h4, 32'h0, 1'b0, 1'b1);
        chk("seq fetch data", exp_rdata(a + 32'h4), core_rdata);
        high_vector_select = hv;
        vector_fetch = 1'b1;
        n = 0;
        core_req(BIU_REQ_FETCH, hv ? `BIU_HIGH_VECTOR_BASE : 32'h0, 32'h0, 1'b0, 1'b0);
        if (hv) begin
            chk("high vector data", exp_rdata(`BIU_HIGH_VECTOR_BASE), core_rdata);
        end else begin
            for (n = 1; n < 8 && vector_from_tcm !== 1'b1; n++) begin
                req_valid = 1'b0;
                @(negedge sys_clk);
            end
            chk("local vector cycles", 32'd3, 32'(n));
        end
        vector_fetch = 1'b0;
        idle(2);
    endtask : fetches
    task automatic complete_run();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    initial begin
        {sys_clk, rst_b, req_valid, req_bufferable, req_seq, req_last, slow} = 7'h0;
        {core_internal, fast_interrupt_request, high_vector_select, vector_fetch} = 4'h0;
        {req_addr, req_wdata, error_cnt, tests_run, cyc, ben_cnt, base_i} = 0;
        req_kind = BIU_REQ_FETCH;
        bus_edge_enable = 1'b1;
        ratio = 1;
        seed = 80108;
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        for (int r = 1; r <= 3; r++) begin
            ratio = r;
            for (int k = 0; k < 4; k++) begin
                slow = 1'($random(seed));
                batch(k == 3 ? 5 : 1 + ($unsigned($random(seed)) % 4), 32'h0, 1'b0);
                batch(4, 32'h000007f8, 1'b1);
                fetches(k[0] ? 32'h00000bf8 : ($random(seed) & 32'h0000fff8), k[1]);
            end
        end
        rst_b = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        batch(2, 32'h0, 1'b0);
        complete_run();
    end
endmodule : testbench
bind biu_master biu_master_monitor biu_master_monitor_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .bus_edge_enable(bus_edge_enable), .hready(hready), .req_valid(req_valid),
    .req_kind(req_kind), .vector_fetch(vector_fetch), .high_vector_select(high_vector_select),
    .core_clock_enable(core_clock_enable), .core_rdata(core_rdata), .rdata_valid(rdata_valid),
    .vector_from_tcm(vector_from_tcm), .haddr(haddr), .htrans(htrans), .hsize(hsize),
    .hrdata(hrdata));
